// >>> hdl/emod_defines.vh
// Opcode codes, status bit positions and reset values for the datapath
`ifndef EMOD_DEFINES_VH
`define EMOD_DEFINES_VH

// ****************************************
// Operation codes
// ****************************************
`define EMOD_OP_DEC_MEM       5'h00
`define EMOD_OP_DEC_WORK      5'h01
`define EMOD_OP_INC_MEM       5'h02
`define EMOD_OP_INC_WORK      5'h03
`define EMOD_OP_MOV_TO_WORK   5'h04
`define EMOD_OP_MOV_TO_MEM    5'h05
`define EMOD_OP_OR_WORK       5'h06
`define EMOD_OP_OR_MEM        5'h07
`define EMOD_OP_RL            5'h08
`define EMOD_OP_RLC           5'h09
`define EMOD_OP_RR            5'h0a
`define EMOD_OP_RRC           5'h0b
`define EMOD_OP_SBC           5'h0c
`define EMOD_OP_SUB           5'h0d
`define EMOD_OP_SDZ           5'h0e
`define EMOD_OP_SIZ           5'h0f
`define EMOD_OP_SET           5'h10
`define EMOD_OP_SET_BIT       5'h11
`define EMOD_OP_SNZ_BIT       5'h12
`define EMOD_OP_SNZ           5'h13

// ****************************************
// Status bit positions
// ****************************************
`define EMOD_ST_BORROW        0
`define EMOD_ST_NIBBLE        1
`define EMOD_ST_NULL          2
`define EMOD_ST_WRAP          3
`define EMOD_ST_SIGN          4
`define EMOD_ST_CHAIN         5

// ****************************************
// Reset values and timing
// ****************************************
`define EMOD_WORK_RST         8'h00
`define EMOD_STATUS_RST       6'h00
`define EMOD_SKIP_CYCLES      2'h3

`endif

// >>> hdl/emod_datapath.v
// Extended direct-memory instruction execution datapath
// Functional notes
// - Decrement writes byte minus one to memory or work, updating null.
// - Increment writes byte plus one to memory or work, updating null.
// - Moves copy memory to work register or back, no status change.
// - OR combines work and memory; work-target form updates null bit.
// - Rotate up wraps bit seven to bit zero, no status change.
// - Rotate up through borrow inserts old borrow, takes out old bit seven.
// - Rotate down wraps bit zero to bit seven, no status change.
// - Rotate down through borrow inserts old borrow, takes old bit zero.
// - Borrow subtract: work minus byte minus inverted borrow, six flags.
// - Borrow bit clears on negative result, sets on zero or positive.
// - Decrement-skip writes memory and skips when new value is zero.
// - Work-target decrement-skip leaves memory, skips when value is zero.
// - Conditional skips take three cycles; taken skip inserts a dummy.
// - Set forces all ones, or one selected bit; no status change.
// - Increment-skip adds one, skips on zero, to memory or work register.
// - Bit test skips when selected bit is one; no status change.
// - Byte test writes byte back unchanged, skips when it is non-zero.
// - Plain subtract stores work minus byte in work register.
// - Any data memory section is addressed directly by full address.
// - Plain subtract updates wrap, null, nibble, borrow, sign, chain.
`timescale 1ns/1ps
`default_nettype none
`include "emod_defines.vh"

module emod_datapath #(
    parameter ADDR_W = 9
) (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // Instruction issue from the sequencer
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [ADDR_W-1:0] op_addr,
    input wire to_work,
    input wire [2:0] bit_sel,
    // Data memory byte read for this operation
    input wire [7:0] mem_rdata,
    // Data memory write back
    output reg mem_we,
    output reg [ADDR_W-1:0] mem_waddr,
    output reg [7:0] mem_wdata,
    // Work register and status
    output reg [7:0] work_register,
    output reg borrow_out_bit,
    output reg nibble_borrow_bit,
    output reg null_result_bit,
    output reg signed_wrap_bit,
    output reg result_sign_bit,
    output reg chained_null_bit,
    // Skip handling
    output reg skip_next,
    output wire busy
);

    // ****************************************
    // Skip sequencing
    // ****************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_HOLD = 2'b01;

    reg [1:0] state;
    reg [1:0] cycle_cnt;

    // Inputs come from the same clock, so nothing is synchronised
    reg [7:0] res;
    reg wr_mem;
    reg wr_work;
    reg skip;
    reg is_skip_op;
    reg new_borrow;
    reg upd_borrow;
    reg upd_null;
    reg upd_arith;
    reg [8:0] diff;
    reg [4:0] ndiff;
    reg ovf;
    reg sub_in;
    reg next_borrow;
    reg next_nibble;
    reg next_null;
    reg next_wrap;
    reg next_sign;
    reg next_chain;
    reg [1:0] next_state;
    reg [1:0] next_cycle_cnt;

    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = 8'h01 << sel;
        end
    endfunction

    // Zero test shared by the null and chain decisions
    function is_zero;
        input [7:0] val;
        begin
            is_zero = (val == 8'h00);
        end
    endfunction

    // ****************************************
    // Operation decode
    // ****************************************
    always @* begin
        res = mem_rdata;
        wr_mem = 1'b0;
        wr_work = 1'b0;
        skip = 1'b0;
        is_skip_op = 1'b0;
        new_borrow = borrow_out_bit;
        upd_borrow = 1'b0;
        upd_null = 1'b0;
        upd_arith = 1'b0;
        diff = 9'h000;
        ndiff = 5'h00;
        ovf = 1'b0;
        sub_in = 1'b0;
        case (op_code)
        `EMOD_OP_DEC_MEM: begin
            res = mem_rdata - 8'h01;
            wr_mem = 1'b1;
            upd_null = 1'b1;
        end
        `EMOD_OP_DEC_WORK: begin
            res = mem_rdata - 8'h01;
            wr_work = 1'b1;
            upd_null = 1'b1;
        end
        `EMOD_OP_INC_MEM: begin
            res = mem_rdata + 8'h01;
            wr_mem = 1'b1;
            upd_null = 1'b1;
        end
        `EMOD_OP_INC_WORK: begin
            res = mem_rdata + 8'h01;
            wr_work = 1'b1;
            upd_null = 1'b1;
        end
        `EMOD_OP_MOV_TO_WORK: begin
            res = mem_rdata;
            wr_work = 1'b1;
        end
        `EMOD_OP_MOV_TO_MEM: begin
            res = work_register;
            wr_mem = 1'b1;
        end
        `EMOD_OP_OR_WORK: begin
            res = work_register | mem_rdata;
            wr_work = 1'b1;
            upd_null = 1'b1;
        end
        `EMOD_OP_OR_MEM: begin
            // Memory form leaves the null bit alone
            res = work_register | mem_rdata;
            wr_mem = 1'b1;
        end
        `EMOD_OP_RL: begin
            res = {mem_rdata[6:0], mem_rdata[7]};
            wr_mem = ~to_work;
            wr_work = to_work;
        end
        `EMOD_OP_RLC: begin
            res = {mem_rdata[6:0], borrow_out_bit};
            new_borrow = mem_rdata[7];
            upd_borrow = 1'b1;
            wr_mem = ~to_work;
            wr_work = to_work;
        end
        `EMOD_OP_RR: begin
            res = {mem_rdata[0], mem_rdata[7:1]};
            wr_mem = ~to_work;
            wr_work = to_work;
        end
        `EMOD_OP_RRC: begin
            res = {borrow_out_bit, mem_rdata[7:1]};
            new_borrow = mem_rdata[0];
            upd_borrow = 1'b1;
            wr_mem = ~to_work;
            wr_work = to_work;
        end
        `EMOD_OP_SBC, `EMOD_OP_SUB: begin
            // Inverted borrow is only subtracted for the with-borrow form
            sub_in = (op_code == `EMOD_OP_SBC) & ~borrow_out_bit;
            diff = {1'b0, work_register} - {1'b0, mem_rdata}
                - {8'h00, sub_in};
            ndiff = {1'b0, work_register[3:0]} - {1'b0, mem_rdata[3:0]}
                - {4'h0, sub_in};
            res = diff[7:0];
            ovf = (work_register[7] ^ mem_rdata[7])
                & (work_register[7] ^ diff[7]);
            new_borrow = ~diff[8];
            upd_borrow = 1'b1;
            upd_arith = 1'b1;
            upd_null = 1'b1;
            // Plain subtract always targets the work register
            wr_work = to_work | (op_code == `EMOD_OP_SUB);
            wr_mem = ~to_work & (op_code == `EMOD_OP_SBC);
        end
        `EMOD_OP_SDZ: begin
            res = mem_rdata - 8'h01;
            wr_mem = ~to_work;
            wr_work = to_work;
            is_skip_op = 1'b1;
            skip = (res == 8'h00);
        end
        `EMOD_OP_SIZ: begin
            res = mem_rdata + 8'h01;
            wr_mem = ~to_work;
            wr_work = to_work;
            is_skip_op = 1'b1;
            skip = (res == 8'h00);
        end
        `EMOD_OP_SET: begin
            res = 8'hff;
            wr_mem = 1'b1;
        end
        `EMOD_OP_SET_BIT: begin
            res = mem_rdata | bit_mask(bit_sel);
            wr_mem = 1'b1;
        end
        `EMOD_OP_SNZ_BIT: begin
            is_skip_op = 1'b1;
            skip = |(mem_rdata & bit_mask(bit_sel));
        end
        `EMOD_OP_SNZ: begin
            res = mem_rdata;
            wr_mem = 1'b1;
            is_skip_op = 1'b1;
            skip = (mem_rdata != 8'h00);
        end
        default: begin
            res = mem_rdata;
        end
        endcase
    end

    assign busy = (state != ST_IDLE);

    // ****************************************
    // Next status values
    // ****************************************
    // Every bit starts from its held value, so operations that leave
    // the status alone (moves, plain rotates, skips) need no case here
    always @* begin
        next_borrow = borrow_out_bit;
        next_nibble = nibble_borrow_bit;
        next_null = null_result_bit;
        next_wrap = signed_wrap_bit;
        next_sign = result_sign_bit;
        next_chain = chained_null_bit;
        if (upd_borrow) begin
            next_borrow = new_borrow;
        end
        if (upd_null) begin
            next_null = is_zero(res);
        end
        if (upd_arith) begin
            // Nibble borrow uses the same sense as the borrow bit
            next_nibble = ~ndiff[4];
            next_wrap = ovf;
            // True sign of the difference, right even when it wraps
            next_sign = diff[7] ^ ovf;
            if (op_code == `EMOD_OP_SBC) begin
                // A multi-byte chain stays zero only if every byte was
                next_chain = chained_null_bit & is_zero(res);
            end else begin
                next_chain = is_zero(res);
            end
        end
    end

    // ****************************************
    // Next skip sequencer state
    // ****************************************
    always @* begin
        next_state = state;
        next_cycle_cnt = cycle_cnt;
        case (state)
        ST_IDLE: begin
            if (op_valid && is_skip_op) begin
                // The issue cycle counts as the first of the three
                next_state = ST_HOLD;
                next_cycle_cnt = `EMOD_SKIP_CYCLES - 2'h1;
            end
        end
        ST_HOLD: begin
            if (cycle_cnt == 2'h1) begin
                next_state = ST_IDLE;
                next_cycle_cnt = 2'h0;
            end else begin
                next_cycle_cnt = cycle_cnt - 2'h1;
            end
        end
        default: begin
            next_state = ST_IDLE;
            next_cycle_cnt = 2'h0;
        end
        endcase
    end

    // ****************************************
    // Result and status registers
    // ****************************************
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_we <= 1'b0;
            mem_waddr <= {ADDR_W{1'b0}};
            mem_wdata <= 8'h00;
            work_register <= `EMOD_WORK_RST;
            {chained_null_bit, result_sign_bit, signed_wrap_bit,
                null_result_bit, nibble_borrow_bit, borrow_out_bit}
                <= `EMOD_STATUS_RST;
            skip_next <= 1'b0;
            state <= ST_IDLE;
            cycle_cnt <= 2'h0;
        end else begin
            mem_we <= 1'b0;
            skip_next <= 1'b0;
            state <= next_state;
            cycle_cnt <= next_cycle_cnt;
            // Issue is only taken while idle: an op offered during the
            // extra cycles of a skip is dropped, not queued
            if (op_valid && (state == ST_IDLE)) begin
                // Full address is passed, so any section is reachable
                mem_waddr <= op_addr;
                mem_wdata <= res;
                mem_we <= wr_mem;
                if (wr_work) begin
                    work_register <= res;
                end
                borrow_out_bit <= next_borrow;
                nibble_borrow_bit <= next_nibble;
                null_result_bit <= next_null;
                signed_wrap_bit <= next_wrap;
                result_sign_bit <= next_sign;
                chained_null_bit <= next_chain;
                skip_next <= is_skip_op & skip;
            end
        end
    end

endmodule
`default_nettype wire

// >>> tb/emod_dp_properties.sv
// Checker for the extended memory datapath
`timescale 1ns/1ps
`default_nettype none
`include "emod_defines.vh"
module emod_dp_props #(
    parameter ADDR_W = 9
) (
    // Clock, reset and issue
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic to_work,
    input wire logic [7:0] mem_rdata,
    // Results
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] work_register,
    input wire logic borrow_out_bit,
    input wire logic null_result_bit,
    input wire logic skip_next,
    input wire logic busy
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire go = op_valid && !busy;
    wire sk = op_code == `EMOD_OP_SDZ || op_code == `EMOD_OP_SIZ
        || op_code == `EMOD_OP_SNZ_BIT || op_code == `EMOD_OP_SNZ;
    // ********
    // Checks
    // ********
    set_ones_a: assert property (
        go && op_code == `EMOD_OP_SET |=> mem_we && mem_wdata == 8'hff
        && mem_waddr == $past(op_addr)) else $error("set missed");
    skip_span_a: assert property (
        go && sk |=> busy [*2] ##1 !busy) else $error("skip length");
    dec_skip_a: assert property (
        go && op_code == `EMOD_OP_SDZ && !to_work && mem_rdata == 8'h01
        |=> skip_next && mem_we && mem_wdata == 8'h00)
        else $error("dec skip missed");
    rot_up_a: assert property (
        go && op_code == `EMOD_OP_RL && !to_work |=> mem_we
        && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("rotate up wrong");
    rot_down_a: assert property (
        go && op_code == `EMOD_OP_RR && to_work |=> !mem_we
        && work_register == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate down wrong");
    rot_borrow_a: assert property (
        go && op_code == `EMOD_OP_RLC
        |=> borrow_out_bit == $past(mem_rdata[7])) else $error("rlc bad");
    move_keep_a: assert property (
        go && op_code == `EMOD_OP_MOV_TO_WORK |=> work_register
        == $past(mem_rdata) && $stable(borrow_out_bit)
        && $stable(null_result_bit)) else $error("move wrong");
    inc_work_a: assert property (
        go && op_code == `EMOD_OP_INC_WORK |=> !mem_we
        && work_register == $past(mem_rdata) + 8'h01
        && null_result_bit == (work_register == 8'h00))
        else $error("inc wrong");
    sub_borrow_a: assert property (
        go && op_code == `EMOD_OP_SUB |=> borrow_out_bit
        == ($past(work_register) >= $past(mem_rdata)))
        else $error("sub borrow wrong");
    cover property (go && sk);
    cover property (skip_next);
    cover property (go && op_code == `EMOD_OP_SBC);
endmodule
bind emod_datapath emod_dp_props #(.ADDR_W(ADDR_W)) i_props (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_addr(op_addr),
    .to_work(to_work),
    .mem_rdata(mem_rdata),
    .mem_we(mem_we),
    .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata),
    .work_register(work_register),
    .borrow_out_bit(borrow_out_bit),
    .null_result_bit(null_result_bit),
    .skip_next(skip_next),
    .busy(busy)
);
`default_nettype wire

// >>> tb/emod_mem_model.sv
// Data memory model that feeds the datapath its operand byte
`timescale 1ns/1ps
`default_nettype none
module emod_mem_model #(
    parameter ADDR_W = 9
) (
    // Read side
    input wire logic ref_clk,
    input wire logic op_valid,
    input wire logic [ADDR_W-1:0] op_addr,
    output logic [7:0] mem_rdata,
    // Write back
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_waddr,
    input wire logic [7:0] mem_wdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    // The byte is only held in the issue cycle, so elsewhere show garbage
    assign mem_rdata = op_valid ? mem[op_addr] : ~mem[op_addr];
    always @(posedge ref_clk) if (mem_we) mem[mem_waddr] <= mem_wdata;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the extended memory datapath
`timescale 1ns/1ps
`default_nettype none
`include "emod_defines.vh"
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [8:0] op_addr = 9'h1a5;
    logic to_work = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    wire [7:0] mem_rdata, mem_wdata, work_register;
    wire [8:0] mem_waddr;
    wire mem_we, skip_next, busy, borrow_out_bit, nibble_borrow_bit;
    wire null_result_bit, signed_wrap_bit, result_sign_bit, chained_null_bit;
    wire [5:0] st = {chained_null_bit, result_sign_bit, signed_wrap_bit,
        null_result_bit, nibble_borrow_bit, borrow_out_bit};
    logic we_s, sk_s;
    int fail_count = 0;
    int checks = 0;
    emod_datapath i_dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .op_valid(op_valid),
        .op_code(op_code),
        .op_addr(op_addr),
        .to_work(to_work),
        .bit_sel(bit_sel),
        .mem_rdata(mem_rdata),
        .mem_we(mem_we),
        .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata),
        .work_register(work_register),
        .borrow_out_bit(borrow_out_bit),
        .nibble_borrow_bit(nibble_borrow_bit),
        .null_result_bit(null_result_bit),
        .signed_wrap_bit(signed_wrap_bit),
        .result_sign_bit(result_sign_bit),
        .chained_null_bit(chained_null_bit),
        .skip_next(skip_next),
        .busy(busy)
    );
    emod_mem_model #(
        .ADDR_W(9)
    ) i_mem (
        .ref_clk(ref_clk),
        .op_valid(op_valid),
        .op_addr(op_addr),
        .mem_rdata(mem_rdata),
        .mem_we(mem_we),
        .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata)
    );
    // ********
    // Helpers
    // ********
    task automatic cv(input string n, input logic [8:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic cb(input string n, input logic e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s: expected %b, seen %b", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Operand is loaded after the previous write back has landed
    task automatic op(input logic [4:0] c, input logic [7:0] v,
            input logic tw = 1'b0, input logic [2:0] b = 3'h0,
            input int nb = 0);
        int n = 0;
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= c;
        to_work <= tw;
        bit_sel <= b;
        #1;
        i_mem.mem[op_addr] = v;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
        we_s = mem_we;
        sk_s = skip_next;
        while (busy !== 1'b0 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cv("busy", nb[8:0], n[8:0]);
        if (n == 4) final_report();
    endtask
    task automatic t_arith();
        op(`EMOD_OP_DEC_MEM, 8'h00);
        cv("wdata", 9'h1ff, {we_s, mem_wdata});
        cv("waddr", 9'h1a5, mem_waddr);
        op(`EMOD_OP_DEC_WORK, 8'h01);
        cv("work", 9'h000, {we_s, work_register});
        cb("null", 1'b1, null_result_bit);
        op(`EMOD_OP_INC_MEM, 8'h7f);
        cv("wdata", 9'h180, {we_s, mem_wdata});
        op(`EMOD_OP_INC_WORK, 8'hff);
        cv("work", 9'h000, {we_s, work_register});
        op(`EMOD_OP_MOV_TO_WORK, 8'h81);
        cv("work", 9'h081, {we_s, work_register});
        cb("null", 1'b1, null_result_bit);
        op(`EMOD_OP_OR_WORK, 8'h5a);
        cv("work", 9'h0db, {we_s, work_register});
        cb("null", 1'b0, null_result_bit);
        op(`EMOD_OP_MOV_TO_MEM, 8'h00);
        cv("wdata", 9'h1db, {we_s, mem_wdata});
        op(`EMOD_OP_OR_MEM, 8'h24);
        cv("wdata", 9'h1ff, {we_s, mem_wdata});
        $display("arith done");
    endtask
    task automatic t_rot();
        op(`EMOD_OP_RL, 8'h81);
        cv("wdata", 9'h103, {we_s, mem_wdata});
        op(`EMOD_OP_RR, 8'h81, 1'b1);
        cv("work", 9'h0c0, {we_s, work_register});
        op(`EMOD_OP_RLC, 8'h80, 1'b1);
        cv("work", 9'h100, {borrow_out_bit, work_register});
        op(`EMOD_OP_RRC, 8'h02);
        cv("wdata", 9'h181, {we_s, mem_wdata});
        cb("borrow", 1'b0, borrow_out_bit);
        $display("rotate done");
    endtask
    task automatic t_sub();
        op(`EMOD_OP_MOV_TO_WORK, 8'h80);
        op(`EMOD_OP_SUB, 8'h01);
        cv("work", 9'h07f, work_register);
        cv("flags", 9'h019, st);
        op(`EMOD_OP_SUB, 8'h7f);
        cv("flags", 9'h027, st);
        op(`EMOD_OP_SBC, 8'h00, 1'b1);
        cv("flags", 9'h027, st);
        op(`EMOD_OP_SBC, 8'h01);
        cv("wdata", 9'h1ff, {we_s, mem_wdata});
        cv("flags", 9'h010, st);
        op(`EMOD_OP_SBC, 8'hff, 1'b1);
        cv("work", 9'h000, work_register);
        cv("flags", 9'h004, st);
        $display("subtract done");
    endtask
    task automatic t_skip();
        op(`EMOD_OP_SDZ, 8'h01, 1'b0, 3'h0, 2);
        cv("wdata", 9'h100, {sk_s, mem_wdata});
        op(`EMOD_OP_SDZ, 8'h05, 1'b1, 3'h0, 2);
        cv("work", 9'h004, {we_s, work_register});
        cb("skip", 1'b0, sk_s);
        op(`EMOD_OP_SIZ, 8'hff, 1'b1, 3'h0, 2);
        cv("work", 9'h100, {sk_s, work_register});
        op(`EMOD_OP_SIZ, 8'h10, 1'b0, 3'h0, 2);
        cv("wdata", 9'h011, {sk_s, mem_wdata});
        op(`EMOD_OP_SNZ_BIT, 8'hfb, 1'b0, 3'h2, 2);
        cb("skip", 1'b0, sk_s);
        op(`EMOD_OP_SNZ_BIT, 8'h04, 1'b0, 3'h2, 2);
        cb("skip", 1'b1, sk_s);
        op(`EMOD_OP_SNZ, 8'h00, 1'b0, 3'h0, 2);
        cb("skip", 1'b0, sk_s);
        op(`EMOD_OP_SNZ, 8'h40, 1'b0, 3'h0, 2);
        cv("wdata", 9'h140, {sk_s, mem_wdata});
        op(`EMOD_OP_SET, 8'h12);
        cv("wdata", 9'h1ff, {we_s, mem_wdata});
        op(`EMOD_OP_SET_BIT, 8'h00, 1'b0, 3'h3);
        cv("wdata", 9'h108, {we_s, mem_wdata});
        cv("flags", 9'h004, st);
        $display("skip done");
    endtask
    initial forever #4 ref_clk = ~ref_clk;
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_arith();
        t_rot();
        t_sub();
        t_skip();
        final_report();
    end
endmodule
`default_nettype wire
